/* File: rtl/fpoc_map.vh */
/*
 Constants for the phrase-program and program-once command sequencer:
 command codes, parameter indices, APB offsets and bit positions.
 Assumes inclusion by bare name from the sequencer file.
*/
`ifndef FPOC_MAP_VH
`define FPOC_MAP_VH

// Command codes
`define FPOC_CMD_RD_ONCE 8'h04
`define FPOC_CMD_PGM 8'h06
`define FPOC_CMD_PGM_ONCE 8'h07

// Parameter index values
`define FPOC_IX_CMD 3'h0
`define FPOC_IX_ADDR 3'h1
`define FPOC_IX_W0 3'h2
`define FPOC_IX_W3 3'h5

// Once phrase index limit and phrase count
`define FPOC_ONCE_MAX 16'h0007
`define FPOC_ONCE_N 8

// APB byte offsets
`define FPOC_OFF_STAT 12'h000
`define FPOC_OFF_IX 12'h004
`define FPOC_OFF_PARAM 12'h008
`define FPOC_OFF_CTRL 12'h00c
`define FPOC_OFF_FLTI 12'h010

// Status bits
`define FPOC_ST_DONE 7
`define FPOC_ST_ACC 5
`define FPOC_ST_PV 4
`define FPOC_ST_MG1 1
`define FPOC_ST_MG0 0

// Control bits
`define FPOC_CT_MODE 0
`define FPOC_CT_PROT 1

// Fault inject bits
`define FPOC_FI_ANY 0
`define FPOC_FI_NC 1

// Algorithm step cycles and phrase select width
`define FPOC_STEP_CYC 4'h3
`define FPOC_PHR_BITS 3

`endif

/* File: rtl/fpoc_seq.v */
/*
 Command sequencer for one-time read, code-flash phrase program and
 one-time program. Holds two small phrase arrays standing in for the
 flash core and the reserved once field.
 Assumes an APB master on pclk and a single clock domain.
*/
// The APB register port and the address map were chosen for this implementation.
`default_nettype none
`include "fpoc_map.vh"
module fpoc_seq #(
  parameter PHRASES = 8,
  parameter ADDR_LIMIT = 18'h0ffff
) (
  // Clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Code-flash read port
  input wire [17:0] rd_addr,
  output reg [15:0] rd_data,
  output reg rd_invalid
);

  // Sequencer states
  // S_IDLE: waiting for a launch, completion flag set
  // S_CHECK: one cycle of launch-time parameter checks
  // S_WRITE: timed program step for either program command
  // S_VERIFY: timed read-back of the programmed phrase
  // S_READ: timed fetch of a reserved phrase
  // S_DONE: raises the completion flag, back to idle
  // Codes are plain binary; unused codes fall back to idle
  localparam S_IDLE = 3'd0;
  localparam S_CHECK = 3'd1;
  localparam S_WRITE = 3'd2;
  localparam S_VERIFY = 3'd3;
  localparam S_READ = 3'd4;
  localparam S_DONE = 3'd5;

  // Storage and control state
  // The two phrase arrays stand in for the flash core and the
  // reserved field; both come out of reset erased, all ones.
  // param_q holds the six parameter words, index 0 to 5.
  // cnt_q times each algorithm step; cmd_q latches the opcode so a
  // later parameter write cannot change the running command.
  // ctrl_q: bit 0 mode allows commands, bit 1 marks region protected.
  // flti_q: test hooks forcing margin errors on read or verify.
  reg [15:0] param_q [0:5];
  reg [63:0] core_q [0:PHRASES-1];
  reg [63:0] once_q [0:`FPOC_ONCE_N-1];
  reg [2:0] param_index_ptr_q;
  reg cmd_complete_flag_q;
  reg access_error_flag_q;
  reg protect_violation_flag_q;
  reg margin_status_hi_q;
  reg margin_status_lo_q;
  reg [1:0] ctrl_q;
  reg [1:0] flti_q;
  reg [2:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] cmd_q;
  integer i;

  // Limitation: the slave never stalls and never reports a bus
  // error, so refused writes are silently dropped instead.
  // APB has no wait states
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Write strobe and phrase views of the parameter words
  // gaddr joins block bits from word 0 with word 1; phr_sel picks a
  // model phrase from the address, once_sel a reserved phrase.
  wire wr_en = psel & penable & pwrite & ce;
  wire [63:0] phr_word = {param_q[5], param_q[4], param_q[3], param_q[2]};
  wire [17:0] gaddr = {param_q[0][1:0], param_q[1]};
  wire [2:0] phr_sel = gaddr[`FPOC_PHR_BITS+2:3];
  wire [2:0] once_sel = param_q[1][2:0];
  // Writing 1 to completion flag clears it, launching
  wire launch = wr_en & (paddr == `FPOC_OFF_STAT) &
                pwdata[`FPOC_ST_DONE] & cmd_complete_flag_q;

  // Checks run on the parameters as they stand one cycle after
  // launch; software cannot change them then, since writes are
  // refused while the completion flag is low.
  // Access errors win over protection: a bad address never also
  // reports a violation, which keeps the two flags exclusive.
  // Launch-time error decoding, shared by all commands
  function [1:0] launch_err;
    input [7:0] cmd;
    input [2:0] ix;
    input [1:0] ctl;
    input [17:0] ga;
    input [15:0] pidx;
    input [63:0] oval;
    reg acc;
    reg pv;
    begin
      acc = 1'b0;
      pv = 1'b0;
      if (!ctl[`FPOC_CT_MODE])
        acc = 1'b1;
      case (cmd)
        `FPOC_CMD_RD_ONCE: begin
          if (ix != `FPOC_IX_ADDR)
            acc = 1'b1;
          if (pidx > `FPOC_ONCE_MAX)
            acc = 1'b1;
        end
        `FPOC_CMD_PGM: begin
          if (ix != `FPOC_IX_W3)
            acc = 1'b1;
          if (ga[2:0] != 3'h0)
            acc = 1'b1;
          if (ga > ADDR_LIMIT)
            acc = 1'b1;
          if (!acc && ctl[`FPOC_CT_PROT])
            pv = 1'b1;
        end
        `FPOC_CMD_PGM_ONCE: begin
          if (ix != `FPOC_IX_W3)
            acc = 1'b1;
          if (pidx > `FPOC_ONCE_MAX)
            acc = 1'b1;
          else if (oval != 64'hffffffffffffffff &&
                   oval != 64'h0000ffffffffffff)
            acc = 1'b1;
        end
        default: acc = 1'b1;
      endcase
      launch_err = {acc, pv};
    end
  endfunction

  wire [1:0] lerr = launch_err(param_q[0][15:8], param_index_ptr_q,
                               ctrl_q, gaddr, param_q[1],
                               once_q[once_sel]);

  // Register write side and the command state machine share one
  // process so that the launch and the parameter lock see the
  // same completion flag value; splitting them would let a write
  // slip in during the launch cycle.
  // Timing per command, counted from the launch edge:
  //   launch error: completion flag set again after two edges
  //   once read: three step cycles, then words land, then done
  //   program commands: write step, verify step, then done
  // The clock enable holds every register, counters included.
  // Sequencer, flags and register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      cmd_q <= 8'h00;
      param_index_ptr_q <= 3'h0;
      cmd_complete_flag_q <= 1'b1;
      access_error_flag_q <= 1'b0;
      protect_violation_flag_q <= 1'b0;
      margin_status_hi_q <= 1'b0;
      margin_status_lo_q <= 1'b0;
      ctrl_q <= 2'h1;
      flti_q <= 2'h0;
      for (i = 0; i < 6; i = i + 1)
        param_q[i] <= 16'h0000;
      for (i = 0; i < PHRASES; i = i + 1)
        core_q[i] <= 64'hffffffffffffffff;
      for (i = 0; i < `FPOC_ONCE_N; i = i + 1)
        once_q[i] <= 64'hffffffffffffffff;
    end else if (ce) begin
      // Index pointer writes accept any value, but parameter access
      // beyond index 5 is dropped on write and reads back as zero.
      // The control and fault registers take effect at the next launch.
      // Register writes, blocked while a command runs
      if (wr_en && cmd_complete_flag_q) begin
        case (paddr)
          `FPOC_OFF_STAT: begin
            // Error flags write-one-to-clear
            if (pwdata[`FPOC_ST_ACC])
              access_error_flag_q <= 1'b0;
            if (pwdata[`FPOC_ST_PV])
              protect_violation_flag_q <= 1'b0;
          end
          `FPOC_OFF_IX: param_index_ptr_q <= pwdata[2:0];
          `FPOC_OFF_PARAM:
            if (param_index_ptr_q <= `FPOC_IX_W3)
              param_q[param_index_ptr_q] <= pwdata[15:0];
          `FPOC_OFF_CTRL: ctrl_q <= pwdata[1:0];
          `FPOC_OFF_FLTI: flti_q <= pwdata[1:0];
          default: ;
        endcase
      end
      // Command state machine
      // A launch while an error flag is pending is ignored: the
      // completion flag stays set and software sees no change.
      case (state_q)
        S_IDLE:
          // Pending errors block the launch, software must clear first
          if (launch && !access_error_flag_q &&
              !protect_violation_flag_q) begin
            cmd_complete_flag_q <= 1'b0;
            margin_status_hi_q <= 1'b0;
            margin_status_lo_q <= 1'b0;
            cmd_q <= param_q[0][15:8];
            state_q <= S_CHECK;
          end
        S_CHECK: begin
          cnt_q <= `FPOC_STEP_CYC;
          if (lerr != 2'b00) begin
            access_error_flag_q <= lerr[1];
            // once commands never reach here with pv set
            protect_violation_flag_q <= lerr[0];
            state_q <= S_DONE;
          end else if (cmd_q == `FPOC_CMD_RD_ONCE)
            state_q <= S_READ;
          else
            state_q <= S_WRITE;
        end
        S_WRITE:
          if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
          else begin
            // Model array write: the real core would pulse its program
            // circuit here for the whole step; one write is enough.
            // program words
            if (cmd_q == `FPOC_CMD_PGM)
              core_q[phr_sel] <= phr_word;
            else
              once_q[once_sel] <= phr_word;
            cnt_q <= `FPOC_STEP_CYC;
            state_q <= S_VERIFY;
          end
        S_VERIFY:
          if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
          else begin
            // any error
            // A non-correctable error is an error too, so both rise
            if (flti_q[`FPOC_FI_ANY] || flti_q[`FPOC_FI_NC] ||
                (cmd_q == `FPOC_CMD_PGM && core_q[phr_sel] != phr_word) ||
                (cmd_q != `FPOC_CMD_PGM && once_q[once_sel] != phr_word))
              margin_status_hi_q <= 1'b1;
            if (flti_q[`FPOC_FI_NC])
              margin_status_lo_q <= 1'b1;
            state_q <= S_DONE;
          end
        S_READ:
          if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
          else begin
            // Words land all at once so software never sees a mix
            // fetch phrase
            param_q[2] <= once_q[once_sel][15:0];
            param_q[3] <= once_q[once_sel][31:16];
            param_q[4] <= once_q[once_sel][47:32];
            param_q[5] <= once_q[once_sel][63:48];
            if (flti_q[`FPOC_FI_ANY] || flti_q[`FPOC_FI_NC])
              margin_status_hi_q <= 1'b1;
            if (flti_q[`FPOC_FI_NC])
              margin_status_lo_q <= 1'b1;
            state_q <= S_DONE;
          end
        S_DONE: begin
          cmd_complete_flag_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Read side is separate: it only looks at the sequencer state.
  // While a once command runs, the code-flash port returns a fixed
  // invalid pattern; the code-flash program command does not block
  // it in this model, since the array write happens in one cycle.
  // prdata is loaded in the setup cycle so the zero-wait access
  // phase always finds it settled; it then holds until the next
  // read setup, which is what the bus contract promises.
  // Registered read data and flash read port
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      rd_data <= 16'h0000;
      rd_invalid <= 1'b0;
    end else if (ce) begin
      rd_invalid <= !cmd_complete_flag_q && cmd_q != `FPOC_CMD_PGM;
      if (!cmd_complete_flag_q && cmd_q != `FPOC_CMD_PGM)
        rd_data <= 16'hdead;
      else
        case (rd_addr[2:1])
          2'h0: rd_data <= core_q[rd_addr[`FPOC_PHR_BITS+2:3]][15:0];
          2'h1: rd_data <= core_q[rd_addr[`FPOC_PHR_BITS+2:3]][31:16];
          2'h2: rd_data <= core_q[rd_addr[`FPOC_PHR_BITS+2:3]][47:32];
          default: rd_data <= core_q[rd_addr[`FPOC_PHR_BITS+2:3]][63:48];
        endcase
      // Setup phase read so data is ready in access phase
      if (psel && !penable && !pwrite)
        case (paddr)
          `FPOC_OFF_STAT: prdata <= {24'h000000, cmd_complete_flag_q,
            1'b0, access_error_flag_q, protect_violation_flag_q,
            2'b00, margin_status_hi_q, margin_status_lo_q};
          `FPOC_OFF_IX: prdata <= {29'h00000000, param_index_ptr_q};
          `FPOC_OFF_PARAM:
            if (param_index_ptr_q <= `FPOC_IX_W3)
              prdata <= {16'h0000, param_q[param_index_ptr_q]};
            else
              prdata <= 32'h00000000;
          `FPOC_OFF_CTRL: prdata <= {30'h00000000, ctrl_q};
          `FPOC_OFF_FLTI: prdata <= {30'h00000000, flti_q};
          default: prdata <= 32'h00000000;
        endcase
    end
  end

  // Known limits of this model
  // Only the three commands are decoded; every other code is an
  // access error. Erase commands and the clock divider live outside.
  // The reserved field is never erased here either, matching the
  // hardware: a programmed phrase stays until the next reset, unless it holds 0x0000ffffffffffff.
  // The protect bit covers the whole array, not a region map.
  // Status bits 6, 3 and 2 read as zero and ignore writes.
  // Offsets beyond the five registers read as zero.
  // Nothing here depends on the clock rate; step lengths are
  // counted in cycles of pclk.

endmodule // fpoc_seq
`default_nettype wire

/* File: tb/fpoc_seq_checker.sv */
/* Port checker for fpoc_seq.
 Assumes one clock, pclk, and async active-low presetn. */
`default_nettype none
module fpoc_seq_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Code-flash read
  input wire logic [17:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic rd_invalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Launch taken at the access edge; read setup loads prdata
  wire launch = psel && penable && pwrite && ce && paddr == 12'h000
    && pwdata[7];
  wire rsetup = psel && !penable && !pwrite && ce;
  property p_ready; pready && !pslverr; endproperty
  a_ready: assert property (p_ready) else $error("apb wait or error");
  property p_inv_data; rd_invalid && $past(rd_invalid) |-> rd_data == 16'hdead;
  endproperty
  a_inv_data: assert property (p_inv_data) else $error("valid data");
  property p_inv_len; $rose(rd_invalid) |-> rd_invalid[*2] ##[1:40] !rd_invalid;
  endproperty
  a_inv_len: assert property (p_inv_len) else $error("busy length");
  property p_inv_cause;
    $rose(rd_invalid) |-> $past(launch) || $past(launch, 2) || $past(launch, 3);
  endproperty
  a_inv_cause: assert property (p_inv_cause) else $error("no launch");
  property p_hold; !rsetup |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("prdata moved");
  property p_freeze;
    !ce |=> $stable(rd_invalid) && $stable(prdata) && $stable(rd_data);
  endproperty
  a_freeze: assert property (p_freeze) else $error("ran while frozen");
  property p_busy_stat;
    rsetup && paddr == 12'h000 |=> !(rd_invalid && prdata[7]);
  endproperty
  a_busy_stat: assert property (p_busy_stat) else $error("done early");
  property p_unmapped; rsetup && paddr == 12'h020 |=> prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
endmodule // fpoc_seq_checker
bind fpoc_seq fpoc_seq_checker u_chk (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rd_addr, .rd_data,
  .rd_invalid);
`default_nettype wire

/* File: tb/fpoc_seq_test.sv */
/* Self-checking bench for fpoc_seq, driven through APB.
 Assumes the checker is bound and the map header is on the path. */
`default_nettype none
`include "fpoc_map.vh"
module fpoc_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, rd_invalid;
  logic [17:0] rd_addr = 18'h0;
  logic [15:0] rd_data;
  int num_errors = 0, n_compared = 0;
  localparam logic [63:0] OD = 64'h0123_4567_89ab_cdef;
  // Cases: op, param 1, block, pointer, ctrl, status
  localparam logic [43:0] ERRS [11] = '{44'h06_0009_0_5_1_a0,
    44'h06_0008_0_4_1_a0, 44'h06_0008_1_5_1_a0, 44'h06_0010_0_5_3_90,
    44'h06_0010_0_5_0_a0, 44'h04_0002_0_1_0_a0, 44'h07_0002_0_5_0_a0,
    44'h04_0008_0_1_1_a0, 44'h04_0002_0_5_1_a0, 44'h07_0008_0_5_3_a0,
    44'h07_0002_0_4_1_a0};
  // 40 MHz clock
  always #12.5 pclk = ~pclk;
  fpoc_seq u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rd_addr, .rd_data, .rd_invalid);
  task automatic final_report();
    $display("compared %0d, mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready, never a fixed count
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      num_errors++;
      final_report();
    end
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rv & m, exp);
  endtask
  task automatic peek(input logic [17:0] a, input logic [15:0] exp);
    rd_addr <= a;
    repeat (2) @(posedge pclk);
    cmp({16'h0, rd_data}, {16'h0, exp});
  endtask
  // Load the parameter words, launch, poll until complete
  task automatic run(input logic [7:0] op, input logic [15:0] p0,
    input logic [15:0] p1, input logic [63:0] w, input logic [2:0] ptr);
    logic [15:0] p [6];
    int k;
    p = '{{op, 8'h00} | p0, p1, w[15:0], w[31:16], w[47:32], w[63:48]};
    apb(1'b1, `FPOC_OFF_STAT, 32'h30);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `FPOC_OFF_IX, 32'(i));
      apb(1'b1, `FPOC_OFF_PARAM, {16'h0, p[i]});
    end
    apb(1'b1, `FPOC_OFF_IX, {29'h0, ptr});
    apb(1'b1, `FPOC_OFF_STAT, 32'h80);
    k = 0;
    do begin
      apb(1'b0, `FPOC_OFF_STAT, 32'h0);
      k++;
    end while (rv[7] !== 1'b1 && k < 40);
    if (k >= 40) begin
      num_errors++;
      final_report();
    end
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(`FPOC_OFF_STAT, 32'hff, 32'h80);
    run(`FPOC_CMD_PGM, 16'h0, 16'h0008, 64'h4444_3333_2222_1111, 3'h5);
    cmp(rv & 32'hff, 32'h80);
    peek(18'h0000e, 16'h4444);
    $display("program test done");
    foreach (ERRS[i]) begin
      apb(1'b1, `FPOC_OFF_CTRL, {30'h0, ERRS[i][9:8]});
      run(ERRS[i][43:36], {14'h0, ERRS[i][17:16]}, ERRS[i][35:20], 64'h0,
        ERRS[i][14:12]);
      cmp(rv & 32'hff, {24'h0, ERRS[i][7:0]});
    end
    apb(1'b1, `FPOC_OFF_CTRL, 32'h1);
    peek(18'h00010, 16'hffff);
    $display("error test done");
    // commands come from the bench, never from flash code
    run(`FPOC_CMD_PGM_ONCE, 16'h0, 16'h0002, OD, 3'h5);
    cmp(rv & 32'hff, 32'h80);
    run(`FPOC_CMD_RD_ONCE, 16'h0, 16'h0002, 64'h0, 3'h1);
    cmp(rv & 32'hff, 32'h80);
    for (int i = 2; i < 6; i++) begin
      apb(1'b1, `FPOC_OFF_IX, 32'(i));
      chk(`FPOC_OFF_PARAM, 32'hffff, {16'h0, OD[16*(i-2) +: 16]});
    end
    run(`FPOC_CMD_PGM_ONCE, 16'h0, 16'h0002, OD, 3'h5);
    cmp(rv & 32'hff, 32'ha0);
    for (int i = 0; i < 2; i++) begin
      run(`FPOC_CMD_PGM_ONCE, 16'h0, 16'h0003, '1, 3'h5);
      cmp(rv & 32'hff, 32'h80);
    end
    $display("once test done");
    for (int i = 1; i < 4; i += 2) begin
      apb(1'b1, `FPOC_OFF_FLTI, 32'(i));
      run(`FPOC_CMD_RD_ONCE, 16'h0, 16'h0002, 64'h0, 3'h1);
      cmp(rv & 32'hff, i == 1 ? 32'h82 : 32'h83);
    end
    apb(1'b1, `FPOC_OFF_FLTI, 32'h0);
    // Freeze briefly; state must not move
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    chk(12'h020, 32'hffffffff, 32'h0);
    $display("margin test done");
    final_report();
  end
endmodule // fpoc_seq_test
`default_nettype wire
